// ---- hdl/ibrl_core.sv ----
// device-side interface-function logic: addressing, remote/local, lockout
`timescale 1ns/100ps
`default_nettype none
// Operation
// R1: remote enable asserted, then listen address: remote and addressed together.
// R2: listener accepts data bytes on seven low data lines, every bit intact.
// R3: distortion select string switches measurement to distortion, key light on.
// R4: after local lockout all front-panel keys are ignored, local key too.
// R5: remote with lockout: local key changes neither remote nor addressed.
// R6: remote enable dropped: leave remote, cancel lockout, stay listener.
// R7: addressed device clear sets rms level measurement, keeps remote and addressed.
// R8: interface clear drops listener addressed state.
// R9: interface clear alone never changes remote state.
// R10: interface clear drops talker state, leaving it unaddressed with remote state unchanged.
// R11: serial poll enable command, value 24, puts device in serial poll mode.
// R12: function number plus special_function_suffix invokes a special function.
// R13: serial poll status function shows 1.0 when active, 0.0 when not.
// R14: interface clear leaves serial poll mode.
// R15: listen address with remote enable deasserted: addressed but stays local.
// R16: without lockout local key in remote returns to local, stays addressed.
// R17: bus address configurable, default 28.
// R18: three-wire handshake; not-ready-for-data held until byte can be taken.
module ibrl_core import ibrl_pkg::*; #(
	parameter logic [4:0] BUS_ADDR = ADDR_DEFAULT // [R17]
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_ren,
	input wire logic i_ifc,
	input wire logic i_dav,
	input wire ibrl_byte_t i_bus,
	input wire logic i_key_local,
	input wire logic i_key_dist,
	input wire logic i_key_rms,
	output logic o_nrfd,
	output logic o_ndac,
	output ibrl_state_t o_state,
	output ibrl_meas_t o_meas,
	output logic o_dist_lamp,
	output logic [7:0] o_right_disp,
	output logic o_sf_strobe,
	output logic [7:0] o_sf_int,
	output logic [3:0] o_sf_frac
);
	// acceptor handshake: 0 idle, 1 byte taken waiting for dav low
	logic acc_busy;
	logic remote, listen, talk, lockout, spoll;
	ibrl_meas_t meas;
	logic [7:0] right_disp;
	// string parser
	logic [7:0] num_int;
	logic [3:0] num_frac;
	logic in_frac, got_m, got_s;
	logic sf_strobe;

	// byte take happens in any cycle with dav high and the acceptor idle
	wire take = i_dav && !acc_busy; // [R18]
	wire [6:0] b7 = i_bus.data[6:0]; // [R2]
	wire is_cmd = take && i_bus.atn;
	wire is_data = take && !i_bus.atn && listen; // [R2]
	wire my_lad = is_cmd && b7[6:5] == GRP_LISTEN && b7[4:0] == BUS_ADDR;
	wire my_tad = is_cmd && b7[6:5] == GRP_TALK && b7[4:0] == BUS_ADDR;
	wire oth_tad = is_cmd && b7[6:5] == GRP_TALK && !my_tad;
	wire unl = is_cmd && b7 == CMD_UNL;
	wire sdc = is_cmd && b7 == CMD_SDC && listen;
	wire dcl = is_cmd && b7 == CMD_DCL;
	wire gtl = is_cmd && b7 == CMD_GTL && listen;
	wire llo = is_cmd && b7 == CMD_LLO;
	wire spe = is_cmd && b7 == CMD_SPE; // [R11]
	wire spd = is_cmd && b7 == CMD_SPD;
	wire is_digit = b7 >= CH_ZERO && b7 <= CH_NINE;
	wire [3:0] dig = b7[3:0];
	// measurement keys count only when local and not locked out; local key only in remote without lockout
	wire keys_ok = !lockout && !remote; // [R4]
	wire local_key = i_key_local && !lockout && remote; // [R5] [R16]

	// handshake: nrfd while a byte is held, ndac released from the take until dav drops
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || i_ifc)
			acc_busy <= 1'b0;
		else if (take)
			acc_busy <= 1'b1;
		else if (!i_dav)
			acc_busy <= 1'b0;
	end
	assign o_nrfd = acc_busy || i_dav; // [R18]
	assign o_ndac = !acc_busy; // [R18]

	// addressing; interface clear beats any byte in flight
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || i_ifc) begin
			listen <= 1'b0; // [R8]
			talk <= 1'b0; // [R10]
		end else begin
			if (my_lad)
				listen <= 1'b1; // [R1] [R15]
			else if (unl)
				listen <= 1'b0;
			if (my_tad)
				talk <= 1'b1;
			else if (oth_tad || (is_cmd && b7 == CMD_UNT))
				talk <= 1'b0;
		end
	end

	// remote/local; ifc not in the reset term on purpose
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || !i_ren) begin
			remote <= 1'b0; // [R6]
			lockout <= 1'b0; // [R6]
		end else begin
			if (my_lad)
				remote <= 1'b1; // [R1] [R9]
			else if (gtl || local_key)
				remote <= 1'b0; // [R16]
			if (llo)
				lockout <= 1'b1; // [R4]
		end
	end

	// serial poll mode
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || i_ifc)
			spoll <= 1'b0; // [R14]
		else if (spe)
			spoll <= 1'b1; // [R11]
		else if (spd)
			spoll <= 1'b0;
	end

	// data string parser: Mn selects, nn.nSP invokes special function
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || i_ifc) begin
			num_int <= 8'h00;
			num_frac <= 4'h0;
			in_frac <= 1'b0;
			got_m <= 1'b0;
			got_s <= 1'b0;
			sf_strobe <= 1'b0;
		end else begin
			sf_strobe <= 1'b0;
			// number must stand with its strobe, so clear it a cycle later
			if (sf_strobe) begin
				num_int <= 8'h00;
				in_frac <= 1'b0;
			end
			if (is_data) begin
				got_s <= 1'b0;
				if (b7 == CH_M) begin
					got_m <= 1'b1;
					num_int <= 8'h00;
					in_frac <= 1'b0;
				end else if (is_digit && got_m) begin
					got_m <= 1'b0;
				end else if (is_digit && in_frac) begin
					num_frac <= dig;
				end else if (is_digit) begin
					num_int <= 8'((num_int * 8'd10) + {4'h0, dig});
				end else if (b7 == CH_DOT) begin
					in_frac <= 1'b1;
					num_frac <= 4'h0;
				end else if (b7 == CH_S) begin
					got_s <= 1'b1;
				end else if (b7 == CH_P && got_s) begin
					sf_strobe <= 1'b1; // [R12]
				end else begin
					num_int <= 8'h00;
					in_frac <= 1'b0;
					got_m <= 1'b0;
				end
			end
		end
	end

	// measurement selection
	wire dist_sel = is_data && got_m && is_digit && dig == DIST_DIGIT;
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst || sdc || dcl)
			meas <= MEAS_RMS; // [R7]
		else if (dist_sel || (keys_ok && i_key_dist))
			meas <= MEAS_DIST; // [R3] [R4]
		else if (is_data && got_m && is_digit)
			meas <= MEAS_OTHER;
		else if (keys_ok && i_key_rms)
			meas <= MEAS_RMS; // [R4]
	end

	// serial poll status function tracks mode while selected
	wire sf_spoll = sf_strobe && num_int == SF_SPOLL_INT
		&& num_frac == SF_SPOLL_FRAC; // [R12]
	logic sp_show;
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			sp_show <= 1'b0;
			right_disp <= DISP_ZERO;
		end else begin
			if (sf_spoll)
				sp_show <= 1'b1;
			else if (sf_strobe)
				sp_show <= 1'b0;
			right_disp <= spoll ? DISP_ONE : DISP_ZERO; // [R13]
		end
	end

	assign o_state = '{remote: remote, listen: listen, talk: talk,
		lockout: lockout, spoll: spoll};
	assign o_meas = meas;
	assign o_dist_lamp = meas == MEAS_DIST; // [R3]
	assign o_right_disp = sp_show ? right_disp : DISP_ZERO;
	assign o_sf_strobe = sf_strobe;
	assign o_sf_int = num_int;
	assign o_sf_frac = num_frac;

	// checks
	chk_rem_listen: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		my_lad && i_ren && !i_ifc |=> remote && listen) // [R1]
		else $error("listen address under ren did not give remote");
	chk_lockout_keys: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		lockout && remote && i_key_local && i_ren && !gtl && !i_ifc
		|=> remote) // [R5]
		else $error("local key left remote under lockout");
	chk_ren_drop: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!i_ren |=> !remote && !lockout) // [R6]
		else $error("ren low did not clear remote and lockout");
	chk_dev_clear: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst) sdc |=> meas == MEAS_RMS) // [R7]
		else $error("device clear did not select rms level");
	chk_ifc_addr: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		i_ifc |=> !listen && !talk && !spoll) // [R8] [R10] [R14]
		else $error("interface clear left addressed or polling");
	chk_ifc_remote: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		i_ifc && i_ren && !i_key_local |=> remote == $past(remote)) // [R9]
		else $error("interface clear changed remote");
	chk_spe_mode: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		spe && !i_ifc |=> spoll) // [R11]
		else $error("serial poll enable ignored");
	chk_spoll_disp: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		sp_show && !sf_strobe ##1 sp_show |-> right_disp ==
		($past(spoll) ? DISP_ONE : DISP_ZERO)) // [R13]
		else $error("right display does not follow poll mode");
	chk_local_listen: assert property (@(posedge i_clk_sys)
		disable iff (i_sys_rst)
		my_lad && !i_ren && !i_ifc |=> listen && !remote) // [R15]
		else $error("listen under local went remote");
	chk_hs_hold: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		take && !i_ifc |=> o_nrfd && !o_ndac) // [R18]
		else $error("handshake not held after byte taken");
	cov_remote: cover property (@(posedge i_clk_sys) my_lad && i_ren);
	cov_dist: cover property (@(posedge i_clk_sys) dist_sel);
	cov_spoll_sf: cover property (@(posedge i_clk_sys) sf_spoll && spoll);
	cov_lockout: cover property (@(posedge i_clk_sys) lockout && i_key_local);
endmodule
`default_nettype wire

// ---- hdl/ibrl_pkg.sv ----
// package: constants and types for the instrument bus remote/local block
package ibrl_pkg;
	// bus command codes (7-bit, attention asserted)
	localparam logic [6:0] CMD_GTL = 7'h01; // go to local, addressed
	localparam logic [6:0] CMD_SDC = 7'h04; // selected device clear
	localparam logic [6:0] CMD_LLO = 7'h11; // local lockout, universal
	localparam logic [6:0] CMD_DCL = 7'h14; // device clear, universal
	localparam logic [6:0] CMD_SPE = 7'h18; // serial poll enable, 24
	localparam logic [6:0] CMD_SPD = 7'h19; // serial poll disable
	localparam logic [6:0] CMD_UNL = 7'h3f; // unlisten
	localparam logic [6:0] CMD_UNT = 7'h5f; // untalk
	localparam logic [1:0] GRP_LISTEN = 2'h1; // bits 6:5 of listen address
	localparam logic [1:0] GRP_TALK = 2'h2; // bits 6:5 of talk address
	localparam logic [4:0] ADDR_DEFAULT = 5'h1c; // factory address 28
	// data string characters
	localparam logic [6:0] CH_M = 7'h4d;
	localparam logic [6:0] CH_S = 7'h53;
	localparam logic [6:0] CH_P = 7'h50;
	localparam logic [6:0] CH_DOT = 7'h2e;
	localparam logic [6:0] CH_ZERO = 7'h30;
	localparam logic [6:0] CH_NINE = 7'h39;
	localparam logic [3:0] DIST_DIGIT = 4'h3; // distortion_select_code M3
	localparam logic [7:0] SF_SPOLL_INT = 8'h3d; // special function 61
	localparam logic [3:0] SF_SPOLL_FRAC = 4'h3; // suffix .3
	localparam logic [7:0] DISP_ONE = 8'h0a; // right display 1.0, tenths
	localparam logic [7:0] DISP_ZERO = 8'h00; // right display 0.0
	typedef enum logic [1:0] {
		MEAS_RMS = 2'b00, // rms_level_measurement
		MEAS_DIST = 2'b01,
		MEAS_OTHER = 2'b10
	} ibrl_meas_t;
	// byte offered by the controller side
	typedef struct packed {
		logic atn;
		logic [7:0] data;
	} ibrl_byte_t;
	// interface state shown to the front panel
	typedef struct packed {
		logic remote;
		logic listen;
		logic talk;
		logic lockout;
		logic spoll;
	} ibrl_state_t;
endpackage

// ---- tb/ibrl_ctl_model.sv ----
// bus controller model: remote enable, interface clear, byte source
`timescale 1ns/100ps
`default_nettype none
module ibrl_ctl_model import ibrl_pkg::*; (
	input wire logic i_clk_sys,
	input wire logic i_nrfd,
	input wire logic i_ndac,
	output logic o_ren,
	output logic o_ifc,
	output logic o_dav,
	output ibrl_byte_t o_bus,
	output logic o_hung
);
	// control lines idle false at time zero; bus starts with atn set and data all ones
	initial begin
		o_ren = 1'b0;
		o_ifc = 1'b0;
		o_dav = 1'b0;
		o_bus = '{atn: 1'b1, data: 8'hff};
		o_hung = 1'b0;
	end
	// bounded wait for the acceptor level; a hang is flagged, not waited out
	task automatic wait_ndac(input logic lvl);
		int n;
		n = 0;
		do begin
			@(posedge i_clk_sys);
			#1;
			n++;
		end while (i_ndac !== lvl && n < 20);
		if (i_ndac !== lvl)
			o_hung = 1'b1;
	endtask
	// one byte under the three-wire handshake
	task automatic send(input logic atn, input logic [7:0] d);
		wait_ndac(1'b1);
		if (i_nrfd !== 1'b0)
			o_hung = 1'b1;
		o_bus = '{atn: atn, data: d};
		o_dav = 1'b1;
		wait_ndac(1'b0);
		o_dav = 1'b0;
		// released lines must not keep showing the old byte
		o_bus = '{atn: ~atn, data: ~d};
		wait_ndac(1'b1);
	endtask
	task automatic set_ren(input logic v);
		@(posedge i_clk_sys);
		#1 o_ren = v;
	endtask
	task automatic pulse_ifc();
		@(posedge i_clk_sys);
		#1 o_ifc = 1'b1;
		@(posedge i_clk_sys);
		#1 o_ifc = 1'b0;
		repeat (2) @(posedge i_clk_sys);
		#1;
	endtask
endmodule
`default_nettype wire

// ---- tb/instrument_bus_remote_local_control_test.sv ----
// testbench: addressing, remote/local, lockout, clear, serial poll
`timescale 1ns/100ps
`default_nettype none
module instrument_bus_remote_local_control_test import ibrl_pkg::*; ;
	logic i_clk_sys = 1'b0;
	logic i_sys_rst = 1'b1;
	logic key_local = 1'b0;
	logic key_dist = 1'b0;
	logic key_rms = 1'b0;
	logic ren, ifc, dav, nrfd, ndac, hung, dist_lamp, sf_strobe;
	ibrl_byte_t bus;
	ibrl_state_t state;
	ibrl_meas_t meas;
	logic [7:0] right_disp, sf_int;
	logic [3:0] sf_frac;
	int fails = 0;
	int n_checks = 0;
	logic [7:0] sf_int_seen = 8'h00;
	logic [3:0] sf_frac_seen = 4'h0;
	int sf_count = 0;
	localparam logic [7:0] LISTEN = {1'b0, GRP_LISTEN, ADDR_DEFAULT};
	localparam logic [7:0] TALK = {1'b0, GRP_TALK, ADDR_DEFAULT};
	// 100 MHz system clock
	always #5 i_clk_sys = ~i_clk_sys;
	ibrl_core uut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.i_ren(ren), .i_ifc(ifc), .i_dav(dav), .i_bus(bus),
		.i_key_local(key_local), .i_key_dist(key_dist),
		.i_key_rms(key_rms), .o_nrfd(nrfd), .o_ndac(ndac),
		.o_state(state), .o_meas(meas), .o_dist_lamp(dist_lamp),
		.o_right_disp(right_disp), .o_sf_strobe(sf_strobe),
		.o_sf_int(sf_int), .o_sf_frac(sf_frac));
	// capture the function number while its one-cycle strobe stands
	always @(posedge i_clk_sys) begin
		if (sf_strobe === 1'b1) begin
			sf_count <= sf_count + 1;
			sf_int_seen <= sf_int;
			sf_frac_seen <= sf_frac;
		end
	end
	ibrl_ctl_model ctl (.i_clk_sys(i_clk_sys), .i_nrfd(nrfd),
		.i_ndac(ndac), .o_ren(ren), .o_ifc(ifc), .o_dav(dav),
		.o_bus(bus), .o_hung(hung));
	task automatic cmp_state(input ibrl_state_t exp);
		n_checks++;
		if (state !== exp) begin
			fails++;
			$display("Error state expected %h seen %h", exp, state);
		end
	endtask
	task automatic cmp_meas(input ibrl_meas_t exp);
		n_checks++;
		if (meas !== exp) begin
			fails++;
			$display("Error meas expected %h seen %h", exp, meas);
		end
	endtask
	task automatic cmp_byte(input string nm, input logic [7:0] exp,
		input logic [7:0] seen);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// key pulse of one cycle, then let it settle
	task automatic press(input logic [2:0] k);
		@(posedge i_clk_sys);
		#1 key_local = k[2];
		key_dist = k[1];
		key_rms = k[0];
		@(posedge i_clk_sys);
		#1 key_local = 1'b0;
		key_dist = 1'b0;
		key_rms = 1'b0;
		repeat (2) @(posedge i_clk_sys);
		#1;
	endtask
	// short mid-run reset so each scenario starts from power-up state
	task automatic restart();
		ctl.set_ren(1'b0);
		i_sys_rst = 1'b1;
		repeat (2) @(posedge i_clk_sys);
		#1 i_sys_rst = 1'b0;
	endtask
	task automatic s_data();
		restart();
		ctl.set_ren(1'b1);
		ctl.send(1'b1, LISTEN);
		cmp_state(5'h18);
		ctl.send(1'b0, 8'h4d);
		ctl.send(1'b0, 8'h33);
		cmp_meas(MEAS_DIST);
		cmp_byte("lamp", 8'h01, {7'h00, dist_lamp});
		ctl.send(1'b1, {1'b0, CMD_SDC});
		cmp_meas(MEAS_RMS);
		cmp_state(5'h18);
	endtask
	task automatic s_lockout();
		restart();
		ctl.set_ren(1'b1);
		ctl.send(1'b1, {1'b0, CMD_LLO});
		ctl.send(1'b1, LISTEN);
		cmp_state(5'h1a);
		press(3'h4);
		cmp_state(5'h1a);
		ctl.set_ren(1'b0);
		repeat (2) @(posedge i_clk_sys);
		cmp_state(5'h08);
	endtask
	task automatic s_local();
		restart();
		ctl.set_ren(1'b1);
		ctl.send(1'b1, LISTEN);
		press(3'h4);
		cmp_state(5'h08);
		ctl.send(1'b1, LISTEN);
		ctl.send(1'b1, {1'b0, CMD_GTL});
		cmp_state(5'h08);
		press(3'h2);
		cmp_meas(MEAS_DIST);
		press(3'h1);
		cmp_meas(MEAS_RMS);
	endtask
	task automatic s_abort();
		restart();
		ctl.send(1'b1, LISTEN);
		cmp_state(5'h08);
		ctl.set_ren(1'b1);
		ctl.send(1'b1, LISTEN);
		ctl.pulse_ifc();
		cmp_state(5'h10);
		ctl.set_ren(1'b0);
		ctl.send(1'b1, TALK);
		cmp_state(5'h04);
		ctl.pulse_ifc();
		cmp_state(5'h00);
	endtask
	task automatic s_spoll();
		string s;
		s = "61.3SP";
		restart();
		ctl.send(1'b1, {1'b0, CMD_SPE});
		cmp_state(5'h01);
		ctl.set_ren(1'b1);
		ctl.send(1'b1, LISTEN);
		for (int i = 0; i < 6; i++)
			ctl.send(1'b0, s[i]);
		repeat (2) @(posedge i_clk_sys);
		cmp_byte("disp", DISP_ONE, right_disp);
		cmp_byte("sf_int", 8'h3d, sf_int_seen);
		cmp_byte("sf_frac", 8'h03, {4'h0, sf_frac_seen});
		cmp_byte("sf_count", 8'h01, 8'(sf_count));
		ctl.pulse_ifc();
		cmp_state(5'h10);
		cmp_byte("disp", DISP_ZERO, right_disp);
	endtask
	task automatic conclude();
		cmp_byte("hung", 8'h00, {7'h00, hung});
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// main sequence: 20 cycles of reset, then every scenario
	initial begin
		repeat (20) @(posedge i_clk_sys);
		#1 i_sys_rst = 1'b0;
		s_data();
		s_lockout();
		s_local();
		s_abort();
		s_spoll();
		conclude();
	end
endmodule
`default_nettype wire
